// file: verilog/qdl_pkg.sv
package qdl_pkg;
    localparam int WORD_BITS       = 16;
    localparam int CODE_BITS       = 12;
    localparam int ADDR_BITS       = 2;
    localparam int NUM_CHANNELS    = 4;
    localparam int ADDR_HI_POS     = 15;
    localparam int ADDR_LO_POS     = 14;
    localparam int CODE_MSB_POS    = 11;
    localparam int FULL_SCALE_DIV  = 4096;
    localparam logic [11:0] RESET_CODE_ZERO = 12'h000;
    localparam logic [11:0] RESET_CODE_MID  = 12'h800;
    localparam logic [15:0] SHIFT_RESET     = 16'h0000;
    localparam logic [1:0]  SYNC_RESET      = 2'b11;
    localparam logic [1:0]  SEED_CYCLES     = 2'h3;
endpackage

// file: verilog/qdl_sync.sv
`timescale 1ns/10ps
// Two-stage synchroniser; only the second stage is visible outside.
module qdl_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    // Data
    input  wire logic d_i,
    output logic      q_o
);
    logic meta_r;
    logic meta_nxt;
    logic q_r;
    logic q_nxt;

    always_comb begin
        meta_nxt = d_i;
        q_nxt    = meta_r;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_r <= RST_VAL;
            q_r    <= RST_VAL;
        end else begin
            meta_r <= meta_nxt;
            q_r    <= q_nxt;
        end
    end

    assign q_o = q_r;
endmodule

// file: verilog/qdl_quad_dac_serial_load.sv
`timescale 1ns/10ps
// Operation
// - Word is address, two spare, twelve code
// - Address first, spare next, code MSB-first
// - Low strobe: address selects channel A to D
// - High strobe holds; low passes code through
// - Reset forces 000 or 800 per select
// - Latched channels keep reset code afterwards
// - Reset leaves shift register untouched
// - Shift on rising edge of select OR clock
// - Select and clock fully interchangeable
// - Codes straight binary over 4096 steps
// - Four channel registers sharing one reference
module qdl_quad_dac_serial_load #(
    parameter int NUM_CH = qdl_pkg::NUM_CHANNELS
) (
    // Clock and device reset
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    // Serial pins from the host
    input  wire logic        serial_clk_i,
    input  wire logic        chip_select_n_i,
    input  wire logic        serial_in_i,
    input  wire logic        channel_update_strobe_n_i,
    input  wire logic        reset_code_select_i,
    // Channel codes, one per converter output
    output logic [11:0]      ch_code_a_o,
    output logic [11:0]      ch_code_b_o,
    output logic [11:0]      ch_code_c_o,
    output logic [11:0]      ch_code_d_o,
    // Status
    output logic [15:0]      shift_word_o,
    output logic [1:0]       channel_select_o
);
    logic sclk_s;
    logic csn_s;
    logic sdi_s;
    logic strobe_n_s;
    logic rsel_s;

    // Idle-high pins reset high so that release never shows a false edge.
    qdl_sync #(
        .RST_VAL (1'b1)
    ) u_sync_clk (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .d_i      (serial_clk_i),
        .q_o      (sclk_s)
    );
    qdl_sync #(
        .RST_VAL (1'b1)
    ) u_sync_cs (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .d_i      (chip_select_n_i),
        .q_o      (csn_s)
    );
    qdl_sync #(
        .RST_VAL (1'b0)
    ) u_sync_sdi (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .d_i      (serial_in_i),
        .q_o      (sdi_s)
    );
    qdl_sync #(
        .RST_VAL (1'b1)
    ) u_sync_ld (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .d_i      (channel_update_strobe_n_i),
        .q_o      (strobe_n_s)
    );
    qdl_sync #(
        .RST_VAL (1'b0)
    ) u_sync_rsel (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .d_i      (reset_code_select_i),
        .q_o      (rsel_s)
    );

    // The shift register must survive reset, so it sits on a reset-free flop and
    // the previous combined clock level is the only state of this pair that reset touches.
    logic        comb_clk;
    logic        comb_prev_r;
    logic        comb_prev_nxt;
    logic [15:0] shift_r;
    logic [15:0] shift_nxt;
    logic        shift_en;

    assign comb_clk = csn_s | sclk_s;
    assign shift_en = comb_clk & ~comb_prev_r;

    always_comb begin
        comb_prev_nxt = comb_clk;
        shift_nxt     = shift_r;
        if (shift_en) begin
            shift_nxt = {shift_r[14:0], sdi_s};
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            comb_prev_r <= 1'b1;
        end else begin
            comb_prev_r <= comb_prev_nxt;
        end
    end

    // No reset term: asserting the device reset leaves the word intact.
    always_ff @(posedge clk_i) begin
        shift_r <= shift_nxt;
    end

    logic [1:0]  addr;
    logic [11:0] code;
    assign addr = {shift_r[qdl_pkg::ADDR_HI_POS], shift_r[qdl_pkg::ADDR_LO_POS]};
    assign code = shift_r[qdl_pkg::CODE_MSB_POS:0];

    // Reset code is picked from the live pin level, since an asynchronous reset
    // flop may only load constants; the pin is steered combinationally.
    logic        rst_code_sel;
    logic [11:0] rst_code;
    logic [11:0] seed_code;
    logic [11:0] ch_r   [NUM_CH];
    logic [11:0] ch_nxt [NUM_CH];
    logic [11:0] ch_out [NUM_CH];
    logic [1:0]  seed_cnt_r;
    logic [1:0]  seed_cnt_nxt;
    logic        seeding;

    assign rst_code_sel = reset_code_select_i;
    assign rst_code     = rst_code_sel ? qdl_pkg::RESET_CODE_MID : qdl_pkg::RESET_CODE_ZERO;
    assign seed_code    = rsel_s ? qdl_pkg::RESET_CODE_MID : qdl_pkg::RESET_CODE_ZERO;
    assign seeding      = (seed_cnt_r != 2'h0);

    // The synchronised select is itself held in reset, so the channels are reseeded
    // until it has settled; meanwhile the outputs keep following the pin.
    always_comb begin
        seed_cnt_nxt = seed_cnt_r;
        if (seeding) begin
            seed_cnt_nxt = seed_cnt_r - 2'h1;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            seed_cnt_r <= qdl_pkg::SEED_CYCLES;
        end else begin
            seed_cnt_r <= seed_cnt_nxt;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            logic sel_nxt;
            always_comb begin
                sel_nxt   = ~strobe_n_s && (addr == 2'(g));
                ch_nxt[g] = ch_r[g];
                if (seeding) begin
                    ch_nxt[g] = seed_code;
                end
                if (sel_nxt) begin
                    ch_nxt[g] = code;
                end
            end

            always_ff @(posedge clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    ch_r[g] <= qdl_pkg::RESET_CODE_ZERO;
                end else begin
                    ch_r[g] <= ch_nxt[g];
                end
            end

            // During reset the outputs show the selected reset code at once.
            assign ch_out[g] = (!arst_n_i || seeding) ? rst_code : ch_r[g];
        end
    endgenerate

    assign ch_code_a_o      = ch_out[0];
    assign ch_code_b_o      = ch_out[1];
    assign ch_code_c_o      = ch_out[2];
    assign ch_code_d_o      = ch_out[3];
    assign shift_word_o     = shift_r;
    assign channel_select_o = addr;
endmodule

// file: dv/qdl_assertions.sv
`timescale 1ns/10ps
module qdl_assertions (
    // Clock, reset and host pins
    input wire logic        clk_i, arst_n_i, serial_clk_i, chip_select_n_i, serial_in_i,
    input wire logic        channel_update_strobe_n_i, reset_code_select_i,
    // Channel codes and status
    input wire logic [11:0] ch_code_a_o, ch_code_b_o, ch_code_c_o, ch_code_d_o,
    input wire logic [15:0] shift_word_o,
    input wire logic [1:0]  channel_select_o
);
    wire        ld_n = channel_update_strobe_n_i;
    wire [47:0] all_c = {ch_code_a_o, ch_code_b_o, ch_code_c_o, ch_code_d_o};
    wire [11:0] rc = reset_code_select_i ? 12'h800 : 12'h000;
    wire [11:0] sel = all_c[47 - 12 * int'(channel_select_o) -: 12];
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    // Checked only under the strobe, because the word powers up unknown.
    property p_sel; (!ld_n && (chip_select_n_i || serial_clk_i)) [*5] |-> $stable(shift_word_o); endproperty
    a_sel: assert property (p_sel) else $error("select");
    property p_idle; (!ld_n) [*2] |-> $stable(shift_word_o); endproperty
    a_idle: assert property (p_idle) else $error("shift");
    property p_hold; ld_n [*8] |-> $stable(all_c); endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_pass; (!ld_n) [*7] |-> sel == shift_word_o[11:0]; endproperty
    a_pass: assert property (p_pass) else $error("pass");
    property p_lat; $fell(ld_n) |-> ##[1:6] sel == shift_word_o[11:0]; endproperty
    a_lat: assert property (p_lat) else $error("latency");
    property p_keep; !ld_n && channel_select_o != 2'h0 |=> $stable(ch_code_a_o); endproperty
    a_keep: assert property (p_keep) else $error("other");
    property p_rst; $rose(arst_n_i) |-> all_c == {4{rc}}; endproperty
    a_rst: assert property (p_rst) else $error("reset");
    property p_rkeep; $rose(arst_n_i) ##0 ld_n [*6] |-> all_c == {4{rc}}; endproperty
    a_rkeep: assert property (p_rkeep) else $error("latched");
    cover property ((!ld_n) [*7]);
    cover property ($rose(arst_n_i) ##0 ld_n [*6]);
    cover property (!ld_n && channel_select_o == 2'h3);
endmodule

// file: dv/qdl_host_model.sv
`timescale 1ns/10ps
module qdl_host_model (
    input  wire logic clk_i,
    output logic      serial_clk_o = 1'b1,
    output logic      chip_select_n_o = 1'b1,
    output logic      serial_in_o = 1'b0,
    output logic      channel_update_strobe_n_o = 1'b1
);
    // Mode 1 uses chip select as the clock, showing that the two pins swap roles.
    task automatic put(input logic m, t, e);
        @(posedge clk_i);
        {serial_clk_o, chip_select_n_o} <= m ? {e, t} : {t, e};
        repeat (3) @(posedge clk_i);
    endtask
    task automatic send(input logic [15:0] w, input logic m, ld);
        for (int i = 15; i >= 0; i--) begin
            serial_in_o <= w[i];
            put(m, 1'b0, 1'b0);
            put(m, 1'b1, 1'b0);
        end
        put(m, 1'b1, 1'b1);
        serial_in_o <= ~w[0];
        if (ld) begin
            channel_update_strobe_n_o <= 1'b0;
            repeat (10) @(posedge clk_i);
            channel_update_strobe_n_o <= 1'b1;
        end
        repeat (8) @(posedge clk_i);
    endtask
endmodule

// file: dv/qdl_quad_dac_serial_load_tb_top.sv
`timescale 1ns/10ps
module qdl_quad_dac_serial_load_tb_top;
    logic        clk_i = 1'b0, arst_n = 1'b0, rsel = 1'b0, sclk, cs_n, sin, ld_n;
    logic [11:0] ca, cb, cc, cd;
    logic [15:0] sw;
    logic [1:0]  csel;
    logic [47:0] ex = '0;
    int          err_total = 0, total_checks = 0, cyc = 0;
    // Each row is strobe enable, mode, then the word; the first row's channel is overwritten by the last.
    logic [17:0] rows [6] = '{18'h2_0FFF, 18'h3_7000, 18'h2_A801, 18'h3_F555, 18'h1_CFFF, 18'h2_1AAA};
    initial forever #5 clk_i = ~clk_i;
    qdl_quad_dac_serial_load i_qdl_quad_dac_serial_load (.clk_i, .arst_n_i(arst_n), .serial_clk_i(sclk),
        .chip_select_n_i(cs_n), .serial_in_i(sin), .channel_update_strobe_n_i(ld_n),
        .reset_code_select_i(rsel), .ch_code_a_o(ca), .ch_code_b_o(cb), .ch_code_c_o(cc),
        .ch_code_d_o(cd), .shift_word_o(sw), .channel_select_o(csel));
    qdl_host_model i_qdl_host_model (.clk_i, .serial_clk_o(sclk), .chip_select_n_o(cs_n),
        .serial_in_o(sin), .channel_update_strobe_n_o(ld_n));
    task automatic chk(input logic [47:0] g, e);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk_i) if (++cyc == 3000) begin
        err_total++;
        stop_test();
    end
    initial begin
        repeat (3) @(posedge clk_i);
        arst_n <= 1'b1;
        @(posedge clk_i);
        #1 chk({ca, cb, cc, cd}, '0);
        @(posedge clk_i);
        foreach (rows[i]) begin
            i_qdl_host_model.send(rows[i][15:0], rows[i][16], rows[i][17]);
            if (rows[i][17]) ex[47 - 12 * int'(rows[i][15:14]) -: 12] = rows[i][11:0];
            chk({ca, cb, cc, cd}, ex);
            chk(48'(sw), 48'(rows[i][15:0]));
            $display("row %0d done", i);
        end
        for (int k = 1; k >= 0; k--) begin
            rsel <= k[0];
            @(posedge clk_i) arst_n <= 1'b0;
            repeat (3) @(posedge clk_i);
            #1 chk({ca, cb, cc, cd}, {4{k[0] ? 12'h800 : 12'h000}});
            chk(48'(sw), 48'(16'h1AAA));
            @(posedge clk_i) arst_n <= 1'b1;
            repeat (8) @(posedge clk_i);
            #1 chk({ca, cb, cc, cd}, {4{k[0] ? 12'h800 : 12'h000}});
            $display("reset test %0d done", k);
            @(posedge clk_i);
        end
        stop_test();
    end
endmodule
bind qdl_quad_dac_serial_load qdl_assertions i_qdl_assertions (.*);
